// ==== rtl/tcc_pkg.sv ====
// Constants, register map and carrier types of the timer capture/compare channels.
package tcc_pkg;

  localparam int NUM_CH = 2;
  localparam int SYNC_W = 3;

  // Register byte addresses on the APB word grid.
  localparam logic [7:0] ADDR_MAIN = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_MOD_HI = 8'h0c;
  localparam logic [7:0] ADDR_MOD_LO = 8'h10;
  localparam logic [NUM_CH-1:0][7:0] ADDR_SC = {8'h28, 8'h14};
  localparam logic [NUM_CH-1:0][7:0] ADDR_VAL_HI = {8'h2c, 8'h18};
  localparam logic [NUM_CH-1:0][7:0] ADDR_VAL_LO = {8'h30, 8'h1c};

  // Timer main control field positions.
  localparam int MC_OVF = 7;
  localparam int MC_OIE = 6;
  localparam int MC_HALT = 5;
  localparam int MC_RST = 4;

  // Channel status and control field positions.
  localparam int SC_FLAG = 7;
  localparam int SC_IE = 6;
  localparam int SC_BUF = 5;
  localparam int SC_MSA = 4;
  localparam int SC_ELSB = 3;
  localparam int SC_ELSA = 2;
  localparam int SC_TOV = 1;
  localparam int SC_MAX = 0;

  // Writable bits of each channel control register; the flag is handled apart.
  localparam logic [NUM_CH-1:0][7:0] SC_WMASK = {8'h5f, 8'h7f};

  // Edge/level field codes.
  localparam logic [1:0] EL_OFF = 2'h0;
  localparam logic [1:0] EL_RISE_TOG = 2'h1;
  localparam logic [1:0] EL_FALL_CLR = 2'h2;
  localparam logic [1:0] EL_ANY_SET = 2'h3;

  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcc_apb_rsp_t;

  typedef struct packed {
    logic [7:0] sc;
    logic [15:0] val;
    logic rd_arm;
    logic hi_rd_lock;
    logic hi_wr_lock;
    logic out;
    logic oe;
    logic irq;
    logic max_eff;
    logic [SYNC_W-1:0] sync;
  } tcc_chan_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] modv;
    logic ovf;
    logic oie;
    logic halt;
    logic ovf_arm;
    logic mod_lock;
    logic ovf_irq;
    logic [15:0] active_cmp;
    logic last_ch1;
    tcc_chan_t [NUM_CH-1:0] ch;
    logic [7:0] prdata;
    logic pready;
    logic pslverr;
  } tcc_state_t;

endpackage

// ==== rtl/tcc_timer_channels.sv ====
// Two-channel 16-bit timer with modulo counter, input capture, output compare and PWM.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps

// Function
// - Counter equal to modulo sets overflow flag and restarts from zero.
// - Writing modulo high byte blocks overflow flag and interrupt until low byte written.
// - Reset loads the modulo value with all ones.
// - Channel flag sets on active capture edge or on compare match.
// - Flag clears by read-while-set then write zero; new event voids clear.
// - Channel interrupt request only while enable and flag are both one.
// - Buffered select bit exists only in channel 0 control; reset clears it.
// - Buffered mode disables channel 1 control and releases channel 1 pin.
// - Nonzero edge/level: mode bit picks capture (0) or compare (1).
// - Zero edge/level: mode bit picks preset level, high (0) or low (1).
// - Capture edge field: 01 rising, 10 falling, 11 either edge.
// - Compare level field: 01 toggle, 10 drive low, 11 drive high.
// - Both edge/level bits zero disconnect channel from pin; reset clears them.
// - Toggle-on-wrap toggles compare pin at every overflow unless full-duty force drives it high; no effect in capture.
// - With toggle-on-wrap, overflow action wins over a simultaneous compare.
// - Full-duty force with toggle-on-wrap gives 100% duty from next period.
// - Value registers hold capture value or compare value.
// - Reading value high byte in capture blocks captures until low byte read.
// - Writing value high byte in compare blocks matches until low byte written.
// - Buffered mode links both channels onto channel 0 pin; the value register last written loads at each overflow.
// - Counter reset bit clears counter and self-clears; with halt holds zero.
module tcc_timer_channels (
  input wire logic pclk,
  input wire logic presetn,
  input wire tcc_pkg::tcc_apb_req_t apb_req,
  output tcc_pkg::tcc_apb_rsp_t apb_rsp,
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_pin_in,
  output logic [tcc_pkg::NUM_CH-1:0] channel_pin_out,
  output logic [tcc_pkg::NUM_CH-1:0] channel_pin_oe,
  output logic [tcc_pkg::NUM_CH-1:0] channel_irq,
  output logic overflow_irq
);

  tcc_pkg::tcc_state_t state_reg;
  tcc_pkg::tcc_state_t state_next;

  function automatic logic [1:0] el_field(input logic [7:0] sc);
    el_field = {sc[tcc_pkg::SC_ELSB], sc[tcc_pkg::SC_ELSA]};
  endfunction

  // Channel is in input capture mode.
  function automatic logic is_capture(input logic [7:0] sc);
    is_capture = (el_field(sc) != tcc_pkg::EL_OFF) & ~sc[tcc_pkg::SC_MSA] & ~sc[tcc_pkg::SC_BUF];
  endfunction

  // Channel is in buffered or unbuffered compare/PWM mode.
  function automatic logic is_compare(input logic [7:0] sc);
    is_compare = (el_field(sc) != tcc_pkg::EL_OFF) & (sc[tcc_pkg::SC_MSA] | sc[tcc_pkg::SC_BUF]);
  endfunction

  // capture edge select
  // Only synchronised edges reach here, so a pin glitch is seen only if a clock edge samples it.
  function automatic logic edge_hit(input logic [1:0] el, input logic rise, input logic fall);
    case (el)
      tcc_pkg::EL_RISE_TOG: edge_hit = rise;
      tcc_pkg::EL_FALL_CLR: edge_hit = fall;
      tcc_pkg::EL_ANY_SET: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // compare pin action
  // The current level is passed in so that the toggle code can invert it and the off code (default) can keep it.
  function automatic logic match_level(input logic [1:0] el, input logic cur);
    case (el)
      tcc_pkg::EL_RISE_TOG: match_level = ~cur;
      tcc_pkg::EL_FALL_CLR: match_level = 1'b0;
      tcc_pkg::EL_ANY_SET: match_level = 1'b1;
      default: match_level = cur;
    endcase
  endfunction

  always_comb begin
    logic acc;
    logic rd_en;
    logic wr_en;
    logic hit;
    logic bufm;
    logic ovf_ev;
    logic cnt_rst;
    logic [7:0] rdv;
    logic [7:0] wd;
    logic [7:0] esc;
    logic cap;
    logic cmp;
    logic rise;
    logic fall;
    logic edge_ok;
    logic match;
    logic [15:0] cmpv;
    acc = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    hit = 1'b0;
    bufm = 1'b0;
    ovf_ev = 1'b0;
    cnt_rst = 1'b0;
    rdv = tcc_pkg::RD_ZERO;
    wd = 8'h00;
    esc = tcc_pkg::SC_RESET;
    cap = 1'b0;
    cmp = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    edge_ok = 1'b0;
    match = 1'b0;
    cmpv = tcc_pkg::CNT_ZERO;
    state_next = state_reg;

    // The slave answers one cycle into the access phase; side effects happen at the completing edge.
    acc = apb_req.psel & apb_req.penable;
    rd_en = acc & state_reg.pready & ~apb_req.pwrite;
    wr_en = acc & state_reg.pready & apb_req.pwrite;
    wd = apb_req.pwdata[7:0];
    bufm = state_reg.ch[0].sc[tcc_pkg::SC_BUF];

    // Read data mux and address decode.
    if (apb_req.paddr == tcc_pkg::ADDR_MAIN) begin
      hit = 1'b1;
      rdv = {state_reg.ovf, state_reg.oie, state_reg.halt, 5'h00};
    end
    if (apb_req.paddr == tcc_pkg::ADDR_CNT_HI) begin
      hit = 1'b1;
      rdv = state_reg.cnt[15:8];
    end
    if (apb_req.paddr == tcc_pkg::ADDR_CNT_LO) begin
      hit = 1'b1;
      rdv = state_reg.cnt[7:0];
    end
    if (apb_req.paddr == tcc_pkg::ADDR_MOD_HI) begin
      hit = 1'b1;
      rdv = state_reg.modv[15:8];
    end
    if (apb_req.paddr == tcc_pkg::ADDR_MOD_LO) begin
      hit = 1'b1;
      rdv = state_reg.modv[7:0];
    end
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      if (apb_req.paddr == tcc_pkg::ADDR_SC[i]) begin
        hit = 1'b1;
        rdv = (i == 1 && bufm) ? tcc_pkg::RD_ZERO : state_reg.ch[i].sc;
      end
      if (apb_req.paddr == tcc_pkg::ADDR_VAL_HI[i]) begin
        hit = 1'b1;
        rdv = state_reg.ch[i].val[15:8];
      end
      if (apb_req.paddr == tcc_pkg::ADDR_VAL_LO[i]) begin
        hit = 1'b1;
        rdv = state_reg.ch[i].val[7:0];
      end
    end
    state_next.pready = acc & ~state_reg.pready;
    state_next.pslverr = acc & ~state_reg.pready & ~hit;
    state_next.prdata = (acc & ~state_reg.pready & ~apb_req.pwrite) ? rdv : tcc_pkg::RD_ZERO;

    // Main control register writes.
    if (wr_en && apb_req.paddr == tcc_pkg::ADDR_MAIN) begin
      state_next.oie = wd[tcc_pkg::MC_OIE];
      state_next.halt = wd[tcc_pkg::MC_HALT];
      cnt_rst = wd[tcc_pkg::MC_RST];
      if (!wd[tcc_pkg::MC_OVF] && state_reg.ovf_arm) begin
        state_next.ovf = 1'b0;
      end
      state_next.ovf_arm = 1'b0;
    end
    if (rd_en && apb_req.paddr == tcc_pkg::ADDR_MAIN && state_reg.ovf) begin
      state_next.ovf_arm = 1'b1;
    end

    if (wr_en && apb_req.paddr == tcc_pkg::ADDR_MOD_HI) begin
      state_next.modv[15:8] = wd;
      state_next.mod_lock = 1'b1;
    end
    if (wr_en && apb_req.paddr == tcc_pkg::ADDR_MOD_LO) begin
      state_next.modv[7:0] = wd;
      state_next.mod_lock = 1'b0;
    end

    ovf_ev = ~state_reg.halt & (state_reg.cnt == state_reg.modv);
    if (cnt_rst) begin
      state_next.cnt = tcc_pkg::CNT_ZERO;
    end else if (ovf_ev) begin
      state_next.cnt = tcc_pkg::CNT_ZERO;
    end else if (!state_reg.halt) begin
      state_next.cnt = state_reg.cnt + tcc_pkg::CNT_STEP;
    end
    if (ovf_ev && !state_reg.mod_lock) begin
      state_next.ovf = 1'b1;
      state_next.ovf_arm = 1'b0;
    end
    state_next.ovf_irq = state_next.ovf & state_next.oie & ~state_next.mod_lock;

    if (!bufm) begin
      state_next.active_cmp = state_reg.ch[0].val;
    end else if (ovf_ev) begin
      state_next.active_cmp = state_reg.last_ch1 ? state_reg.ch[1].val : state_reg.ch[0].val;
    end

    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      esc = (i == 1 && bufm) ? tcc_pkg::SC_RESET : state_reg.ch[i].sc;
      cap = is_capture(esc);
      cmp = is_compare(esc);

      // Only the second and third synchroniser stages feed the edge detector.
      state_next.ch[i].sync = {state_reg.ch[i].sync[1:0], channel_pin_in[i]};
      rise = state_reg.ch[i].sync[1] & ~state_reg.ch[i].sync[2];
      fall = ~state_reg.ch[i].sync[1] & state_reg.ch[i].sync[2];

      edge_ok = edge_hit(el_field(esc), rise, fall);

      // channel 0 compares against linked buffer
      cmpv = (i == 0 && bufm) ? state_reg.active_cmp : state_reg.ch[i].val;
      match = cmp & ~state_reg.halt & ~state_reg.ch[i].hi_wr_lock & (state_reg.cnt == cmpv);

      if (wr_en && apb_req.paddr == tcc_pkg::ADDR_SC[i] && !(i == 1 && bufm)) begin
        state_next.ch[i].sc = (state_reg.ch[i].sc & ~tcc_pkg::SC_WMASK[i]) | (wd & tcc_pkg::SC_WMASK[i]);
        if (!wd[tcc_pkg::SC_FLAG] && state_reg.ch[i].rd_arm) begin
          state_next.ch[i].sc[tcc_pkg::SC_FLAG] = 1'b0;
        end
        state_next.ch[i].rd_arm = 1'b0;
      end
      if (rd_en && apb_req.paddr == tcc_pkg::ADDR_SC[i] && esc[tcc_pkg::SC_FLAG]) begin
        state_next.ch[i].rd_arm = 1'b1;
      end

      if (wr_en && apb_req.paddr == tcc_pkg::ADDR_VAL_HI[i]) begin
        state_next.ch[i].val[15:8] = wd;
        state_next.ch[i].hi_wr_lock = cmp | (i == 1 && bufm);
      end
      if (wr_en && apb_req.paddr == tcc_pkg::ADDR_VAL_LO[i]) begin
        state_next.ch[i].val[7:0] = wd;
        state_next.ch[i].hi_wr_lock = 1'b0;
        state_next.last_ch1 = (i == 1);
      end
      if (rd_en && apb_req.paddr == tcc_pkg::ADDR_VAL_HI[i] && cap) begin
        state_next.ch[i].hi_rd_lock = 1'b1;
      end
      if (rd_en && apb_req.paddr == tcc_pkg::ADDR_VAL_LO[i]) begin
        state_next.ch[i].hi_rd_lock = 1'b0;
      end

      // capture stores count and sets flag
      if (cap && edge_ok && !state_reg.ch[i].hi_rd_lock) begin
        state_next.ch[i].val = state_reg.cnt;
        state_next.ch[i].sc[tcc_pkg::SC_FLAG] = 1'b1;
        state_next.ch[i].rd_arm = 1'b0;
      end
      // match flag, set wins over clear
      if (match) begin
        state_next.ch[i].sc[tcc_pkg::SC_FLAG] = 1'b1;
        state_next.ch[i].rd_arm = 1'b0;
      end

      // full-duty change waits for the period boundary
      if (ovf_ev || !cmp) begin
        state_next.ch[i].max_eff = esc[tcc_pkg::SC_MAX];
      end

      if (el_field(esc) == tcc_pkg::EL_OFF) begin
        state_next.ch[i].out = ~esc[tcc_pkg::SC_MSA];
      end else if (cmp) begin
        if (esc[tcc_pkg::SC_TOV] && ovf_ev) begin
          state_next.ch[i].out = state_next.ch[i].max_eff ? 1'b1 : ~state_reg.ch[i].out;
        end else if (match && !(esc[tcc_pkg::SC_TOV] && state_reg.ch[i].max_eff)) begin
          state_next.ch[i].out = match_level(el_field(esc), state_reg.ch[i].out);
        end
      end
      state_next.ch[i].oe = cmp;
      state_next.ch[i].irq = state_next.ch[i].sc[tcc_pkg::SC_FLAG] & state_next.ch[i].sc[tcc_pkg::SC_IE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.modv <= tcc_pkg::MOD_RESET;
      // Counter starts halted until software releases it.
      state_reg.halt <= 1'b1;
      // Every field is named here so that a field added later is not left to the blanket clear by accident.
      state_reg.cnt <= tcc_pkg::CNT_ZERO;
      state_reg.ovf <= 1'b0;
      state_reg.oie <= 1'b0;
      state_reg.ovf_arm <= 1'b0;
      state_reg.mod_lock <= 1'b0;
      state_reg.ovf_irq <= 1'b0;
      state_reg.active_cmp <= tcc_pkg::VAL_RESET;
      state_reg.last_ch1 <= 1'b0;
      state_reg.prdata <= tcc_pkg::RD_ZERO;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
        state_reg.ch[i].sc <= tcc_pkg::SC_RESET;
        state_reg.ch[i].val <= tcc_pkg::VAL_RESET;
        // Pin idles high like a released preset, so no compare output glitches low at start.
        state_reg.ch[i].out <= 1'b1;
        state_reg.ch[i].rd_arm <= 1'b0;
        state_reg.ch[i].hi_rd_lock <= 1'b0;
        state_reg.ch[i].hi_wr_lock <= 1'b0;
        state_reg.ch[i].oe <= 1'b0;
        state_reg.ch[i].irq <= 1'b0;
        state_reg.ch[i].max_eff <= 1'b0;
        state_reg.ch[i].sync <= '0;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    apb_rsp.prdata = {24'h000000, state_reg.prdata};
    apb_rsp.pready = state_reg.pready;
    apb_rsp.pslverr = state_reg.pslverr;
    overflow_irq = state_reg.ovf_irq;
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      channel_pin_out[i] = state_reg.ch[i].out;
      channel_pin_oe[i] = state_reg.ch[i].oe;
      channel_irq[i] = state_reg.ch[i].irq;
    end
  end

endmodule // tcc_timer_channels

// ==== tb/tcc_chk.sv ====
// Port checker for the timer capture/compare channels.
`timescale 1ns/10ps
module tcc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire tcc_pkg::tcc_apb_req_t apb_req,
  input wire tcc_pkg::tcc_apb_rsp_t apb_rsp,
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_pin_in,
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_pin_out,
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_pin_oe,
  input wire logic [tcc_pkg::NUM_CH-1:0] channel_irq,
  input wire logic overflow_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [7:0] a;
  logic [7:0] d;
  // Per channel: irq enable, mode A, edge/level. Mode: buffered, overflow enable, modulo pending.
  logic [1:0][3:0] cfg_reg;
  logic [1:0][3:0] old_reg;
  logic [2:0] mode_reg;
  logic [2:0] mold_reg;
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  assign a = apb_req.paddr;
  assign d = apb_req.pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
      old_reg <= '0;
      mode_reg <= '0;
      mold_reg <= '0;
    end else begin
      old_reg <= cfg_reg;
      mold_reg <= mode_reg;
      if (wr && a == tcc_pkg::ADDR_SC[0]) cfg_reg[0] <= {d[6], d[4], d[3:2]};
      if (wr && a == tcc_pkg::ADDR_SC[1] && !mode_reg[2]) cfg_reg[1] <= {d[6], d[4], d[3:2]};
      if (wr && a == tcc_pkg::ADDR_SC[0]) mode_reg[2] <= d[5];
      if (wr && a == tcc_pkg::ADDR_MAIN) mode_reg[1] <= d[6];
      if (wr && a == tcc_pkg::ADDR_MOD_HI) mode_reg[0] <= 1'b1;
      if (wr && a == tcc_pkg::ADDR_MOD_LO) mode_reg[0] <= 1'b0;
    end
  end
  ready_late_a: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("pready late");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready too long");
  error_pair_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("pslverr outside answer");
  rdata_idle_a: assert property (!(apb_rsp.pready && !apb_req.pwrite) |-> apb_rsp.prdata == 32'h0)
    else $error("prdata not zero");
  mod_hold_a: assert property (mode_reg[0] && mold_reg[0] |-> !overflow_irq)
    else $error("overflow irq while modulo pending");
  ovf_gate_a: assert property (!mode_reg[1] && !mold_reg[1] |-> !overflow_irq)
    else $error("overflow irq while disabled");
  for (genvar i = 0; i < 2; i++) begin : g_ch
    pin_owner_a: assert property (cfg_reg[i] == old_reg[i] && mode_reg[2] == mold_reg[2] |->
      channel_pin_oe[i] == (cfg_reg[i][1:0] != 2'h0 && (cfg_reg[i][2] || mode_reg[2] && i == 0) && !(mode_reg[2] && i == 1)))
      else $error("pin enable wrong");
    preset_level_a: assert property (cfg_reg[i][1:0] == 2'h0 && cfg_reg[i] == old_reg[i] && $stable(old_reg[i])
      && (i == 0 || !mode_reg[2]) |-> channel_pin_out[i] == !cfg_reg[i][2])
      else $error("preset level wrong");
    chan_gate_a: assert property (!cfg_reg[i][3] && !old_reg[i][3] |-> !channel_irq[i])
      else $error("channel irq while disabled");
  end
  cover property (overflow_irq);
  cover property (channel_irq[1]);
  cover property (apb_rsp.pslverr);
endmodule // tcc_chk

// ==== tb/tcc_pin_model.sv ====
// External signal source on the channel pins.
`timescale 1ns/10ps
module tcc_pin_model (
  input wire logic pclk,
  input wire logic [1:0] level,
  output logic [1:0] pin
);
  always_ff @(posedge pclk) pin <= level;
endmodule // tcc_pin_model

// ==== tb/timer_capture_compare_channels_bench.sv ====
// Self-checking bench for the timer capture/compare channels.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module timer_capture_compare_channels_bench;
  localparam logic [2:0][1:0] CODES = {2'h1, 2'h3, 2'h2};
  localparam logic [2:0] PINS = 3'b010;
  logic pclk;
  logic presetn;
  tcc_pkg::tcc_apb_req_t apb_req;
  tcc_pkg::tcc_apb_rsp_t apb_rsp;
  logic [1:0] ext;
  logic [1:0] pin_ext;
  logic [1:0] pin_w;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] ch_irq;
  logic ovf_irq;
  logic [7:0] rdv;
  logic [7:0] cnt_lo;
  logic err;
  logic seen;
  int n_errors;
  int num_checks;
  int n;
  assign pin_w = (pin_oe & pin_out) | (~pin_oe & pin_ext);
  tcc_timer_channels i_tcc_timer_channels (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .channel_pin_in(pin_w), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .channel_irq(ch_irq),
    .overflow_irq(ovf_irq));
  tcc_pin_model i_tcc_pin_model (.pclk(pclk), .level(ext), .pin(pin_ext));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] dv);
    int k;
    k = 0;
    apb_req <= '{1'b1, 1'b0, w, a, {24'h000000, dv}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 20);
    rdv = apb_rsp.prdata[7:0];
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (apb_rsp.pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    xfer(1'b1, a, dv);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK("reg read", e, rdv)
  endtask
  // Waits a bounded time for any selected interrupt: bit 2 overflow, bits 1:0 channels.
  task automatic wait_hi(input logic [2:0] sel, input int lim);
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(posedge pclk);
      seen = |({ovf_irq, ch_irq} & sel);
    end
  endtask
  task automatic toggles();
    logic p;
    n = 0;
    p = pin_out[0];
    repeat (64) begin
      @(posedge pclk);
      if (pin_out[0] !== p) n++;
      p = pin_out[0];
    end
  endtask
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    ext = 2'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(tcc_pkg::ADDR_MAIN, 8'h20);
    rd(tcc_pkg::ADDR_MOD_HI, 8'hff);
    rd(tcc_pkg::ADDR_MOD_LO, 8'hff);
    rd(tcc_pkg::ADDR_SC[0], 8'h00);
    rd(8'h40, 8'h00);
    `CHK("slave error", 1'b1, err)
    wr(tcc_pkg::ADDR_SC[1], 8'hff);
    rd(tcc_pkg::ADDR_SC[1], 8'h5f);
    wr(tcc_pkg::ADDR_SC[1], 8'h00);
    wr(tcc_pkg::ADDR_MOD_HI, 8'h00);
    wr(tcc_pkg::ADDR_MOD_LO, 8'h0f);
    wr(tcc_pkg::ADDR_MAIN, 8'h30);
    rd(tcc_pkg::ADDR_CNT_LO, 8'h00);
    wr(tcc_pkg::ADDR_MOD_HI, 8'h00);
    wr(tcc_pkg::ADDR_MAIN, 8'h40);
    wait_hi(3'h4, 40);
    `CHK("overflow held", 1'b0, seen)
    wr(tcc_pkg::ADDR_MOD_LO, 8'h0f);
    wait_hi(3'h4, 40);
    `CHK("overflow irq", 1'b1, seen)
    wr(tcc_pkg::ADDR_MAIN, 8'h60);
    rd(tcc_pkg::ADDR_MAIN, 8'he0);
    wr(tcc_pkg::ADDR_MAIN, 8'h60);
    rd(tcc_pkg::ADDR_MAIN, 8'h60);
    wr(tcc_pkg::ADDR_VAL_HI[0], 8'h00);
    wr(tcc_pkg::ADDR_VAL_LO[0], 8'h05);
    for (int c = 0; c < 3; c++) begin
      wr(tcc_pkg::ADDR_MAIN, 8'h30);
      wr(tcc_pkg::ADDR_SC[0], {4'h5, CODES[c], 2'h0});
      wr(tcc_pkg::ADDR_MAIN, 8'h00);
      wait_hi(3'h1, 40);
      `CHK("compare pin", PINS[c], pin_out[0])
      wr(tcc_pkg::ADDR_MAIN, 8'h30);
      rd(tcc_pkg::ADDR_SC[0], {4'hd, CODES[c], 2'h0});
    end
    wr(tcc_pkg::ADDR_SC[0], 8'h54);
    rd(tcc_pkg::ADDR_SC[0], 8'h54);
    wr(tcc_pkg::ADDR_VAL_HI[0], 8'h00);
    wr(tcc_pkg::ADDR_MAIN, 8'h00);
    wait_hi(3'h1, 40);
    `CHK("match held", 1'b0, seen)
    wr(tcc_pkg::ADDR_VAL_LO[0], 8'h0f);
    wait_hi(3'h1, 40);
    `CHK("match after low", 1'b1, seen)
    wr(tcc_pkg::ADDR_MAIN, 8'h30);
    wr(tcc_pkg::ADDR_SC[0], 8'h5a);
    wr(tcc_pkg::ADDR_MAIN, 8'h00);
    toggles();
    `CHK("wrap toggles", 4, n)
    wr(tcc_pkg::ADDR_SC[0], 8'h5b);
    toggles();
    toggles();
    `CHK("full duty", 0, n)
    `CHK("full duty pin", 1'b1, pin_out[0])
    for (int e = 1; e < 4; e++) begin
      xfer(1'b0, tcc_pkg::ADDR_SC[1], 8'h00);
      wr(tcc_pkg::ADDR_SC[1], {4'h4, e[1:0], 2'h0});
      ext <= 2'h2;
      wait_hi(3'h2, 12);
      `CHK("rise capture", e[0], seen)
      xfer(1'b0, tcc_pkg::ADDR_SC[1], 8'h00);
      wr(tcc_pkg::ADDR_SC[1], {4'h4, e[1:0], 2'h0});
      ext <= 2'h0;
      wait_hi(3'h2, 12);
      `CHK("fall capture", e[1], seen)
    end
    xfer(1'b0, tcc_pkg::ADDR_SC[1], 8'h00);
    wr(tcc_pkg::ADDR_SC[1], 8'h4c);
    xfer(1'b0, tcc_pkg::ADDR_VAL_HI[1], 8'h00);
    ext <= 2'h2;
    wait_hi(3'h2, 12);
    `CHK("capture locked", 1'b0, seen)
    xfer(1'b0, tcc_pkg::ADDR_VAL_LO[1], 8'h00);
    wr(tcc_pkg::ADDR_MAIN, 8'h20);
    xfer(1'b0, tcc_pkg::ADDR_CNT_LO, 8'h00);
    cnt_lo = rdv;
    ext <= 2'h0;
    wait_hi(3'h2, 12);
    `CHK("capture unlocked", 1'b1, seen)
    rd(tcc_pkg::ADDR_VAL_LO[1], cnt_lo);
    wr(tcc_pkg::ADDR_MAIN, 8'h30);
    xfer(1'b0, tcc_pkg::ADDR_SC[0], 8'h00);
    wr(tcc_pkg::ADDR_SC[0], 8'h2c);
    rd(tcc_pkg::ADDR_SC[0], 8'h2c);
    wr(tcc_pkg::ADDR_SC[1], 8'h44);
    rd(tcc_pkg::ADDR_SC[1], 8'h00);
    report_and_stop();
  end
endmodule // timer_capture_compare_channels_bench
bind tcc_timer_channels tcc_chk i_tcc_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .channel_irq(channel_irq), .overflow_irq(overflow_irq));
